// ==== rtl/pocd_pkg.sv ====
// Purpose: Shared constants for the output command decoder and its host
// Assumes: 16-bit command and status words, command bit n is word bit [n]
// Notes: Status bit positions and host register indices are local picks
package pocd_pkg;
  localparam int CW = 16;
  // Command bit positions
  localparam int B_F0   = 0;
  localparam int B_F1   = 1;
  localparam int B_DATA = 2;
  localparam int B_SVC  = 3;
  localparam int B_EOB  = 4;
  localparam int B_TERM = 5;
  localparam int B_CTL  = 6;
  localparam int B_MPE  = 7;
  localparam int B_MODE = 1;
  localparam int B_DIR  = 4;
  // Status bit positions
  localparam int S_NOERR = 0;
  localparam int S_XERR  = 1;
  localparam int S_PERR  = 2;
  localparam int S_INOP  = 3;
  localparam int S_MPE   = 4;
  localparam int S_BUSY  = 8;
  localparam int S_NRDY  = 9;
  // Host register indices
  localparam logic [3:0] R_CMD  = 4'h0;
  localparam logic [3:0] R_STAT = 4'h1;
  localparam logic [3:0] R_IRQ  = 4'h2;
  localparam logic [3:0] R_ADR  = 4'h3;
  localparam logic [3:0] R_WCNT = 4'h4;
  localparam logic [3:0] R_FLAG = 4'h5;
  // Reset values
  localparam logic [CW-1:0] WORD_RST = 16'h0000;

  typedef enum logic [1:0] {FMT_SELECT, FMT_CONTROL, FMT_INIT} pocd_fmt_t;

  // Classify a command word by its two format bits
  function automatic pocd_fmt_t pocd_classify(input logic [CW-1:0] w);
    pocd_fmt_t f;
    f = FMT_INIT;
    if (!w[B_F0] && !w[B_F1]) begin
      f = FMT_SELECT;
    end else if (!w[B_F0]) begin
      f = FMT_CONTROL;
    end
    return f;
  endfunction
endpackage

// ==== rtl/pocd_bus_if.sv ====
// Purpose: I/O bus between the host subsystem and one peripheral controller
// Assumes: One clock, both ends drive only from flip-flops
// Notes: Interrupt lines are levels; acks are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface pocd_bus_if;
  // Host to controller
  logic                   cmd_valid;
  logic [pocd_pkg::CW-1:0] cmd_word;
  logic                   stat_rd;
  logic                   data_ack;
  logic                   svc_ack;
  // Controller to host
  logic [pocd_pkg::CW-1:0] stat_word;
  logic                   data_irq;
  logic                   svc_irq;

  modport dev (
    input  cmd_valid, cmd_word, stat_rd, data_ack, svc_ack,
    output stat_word, data_irq, svc_irq
  );
  modport host (
    output cmd_valid, cmd_word, stat_rd, data_ack, svc_ack,
    input  stat_word, data_irq, svc_irq
  );
endinterface
`default_nettype wire

// ==== rtl/pocd_dev.sv ====
// Purpose: Peripheral controller end: decodes output command words
// Assumes: Transfer engine on the user side reports need, count and done
// Notes: A command is applied in the cycle after it is strobed
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pocd_dev #(
  parameter bit HAS_BLOCK = 1'b1,
  parameter bit ABORT_MPE = 1'b0
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // I/O bus
  pocd_bus_if.dev                      bus,
  // Transfer engine events
  input  wire logic                    word_need,
  input  wire logic                    word_taken,
  input  wire logic                    count_zero,
  input  wire logic                    checks_done,
  input  wire logic                    xfer_err,
  input  wire logic                    dev_perr,
  input  wire logic                    inoperable,
  // Orders to the transfer engine
  output logic                         select_go_q,
  output logic                         init_go_q,
  output logic                         ctl_go_q,
  output logic                         stop_q,
  output logic                         abort_q,
  output logic [pocd_pkg::CW-1:0]      cmd_q,
  output logic                         busy_q,
  output logic                         block_mode_q,
  output logic                         dir_in_q
);
  logic [pocd_pkg::CW-1:0] cmd_d;
  logic                    select_go_d, init_go_d, ctl_go_d, stop_d, abort_d;
  logic                    busy_d, block_mode_d, dir_in_d;
  logic                    data_conn_q, data_conn_d, svc_conn_q, svc_conn_d;
  logic                    data_pend_q, data_pend_d, svc_pend_q, svc_pend_d;
  logic                    rdy_q, rdy_d;
  logic                    xerr_q, xerr_d, perr_q, perr_d, mpe_q, mpe_d;
  logic [pocd_pkg::CW-1:0] stat_q, stat_d;
  pocd_pkg::pocd_fmt_t     fmt;
  logic                    take, is_eob, is_term, clr_ok, data_evt, svc_evt;
  logic [pocd_pkg::CW-1:0] w;

  // Command decode and controller state
  always_comb begin
    w = bus.cmd_word;
    fmt = pocd_pkg::pocd_classify(w);
    take = bus.cmd_valid;
    is_eob = (fmt == pocd_pkg::FMT_CONTROL) && w[pocd_pkg::B_EOB];
    is_term = (fmt == pocd_pkg::FMT_CONTROL) && w[pocd_pkg::B_TERM];
    clr_ok = take && !busy_q && !is_eob && !is_term;
    cmd_d = cmd_q;
    select_go_d = 1'b0;
    init_go_d = 1'b0;
    ctl_go_d = 1'b0;
    stop_d = 1'b0;
    abort_d = 1'b0;
    busy_d = busy_q;
    block_mode_d = block_mode_q;
    dir_in_d = dir_in_q;
    data_conn_d = data_conn_q;
    svc_conn_d = svc_conn_q;
    data_pend_d = data_pend_q;
    svc_pend_d = svc_pend_q;
    xerr_d = xerr_q;
    perr_d = perr_q;
    mpe_d = mpe_q;
    rdy_d = rdy_q;
    data_evt = 1'b0;
    svc_evt = 1'b0;
    // Stored status cleared first so that a new error wins
    if (clr_ok) begin
      xerr_d = 1'b0;
      perr_d = 1'b0;
      mpe_d = 1'b0;
    end
    // Interrupt acknowledge from the queue update
    if (bus.data_ack) begin
      data_pend_d = 1'b0;
    end
    if (bus.svc_ack) begin
      svc_pend_d = 1'b0;
    end
    if (take) begin
      unique case (fmt)
        pocd_pkg::FMT_SELECT: begin
          if (!(busy_q && block_mode_q)) begin
            select_go_d = 1'b1;
            cmd_d = w;
          end
        end
        pocd_pkg::FMT_CONTROL: begin
          if (is_eob || is_term) begin
            if (is_eob) begin
              data_evt = data_conn_q;
            end
            if (is_term) begin
              stop_d = 1'b1;
              data_pend_d = 1'b0;
              svc_evt = !busy_q;
              if (w[pocd_pkg::B_MPE]) begin
                mpe_d = HAS_BLOCK;
                abort_d = ABORT_MPE;
              end
            end
          end else begin
            data_conn_d = w[pocd_pkg::B_DATA];
            svc_conn_d = w[pocd_pkg::B_SVC];
            if (!w[pocd_pkg::B_DATA]) begin
              data_pend_d = 1'b0;
            end
            if (!w[pocd_pkg::B_SVC]) begin
              svc_pend_d = 1'b0;
            end
            if (w[pocd_pkg::B_CTL] && !busy_q) begin
              ctl_go_d = 1'b1;
              cmd_d = w;
            end
          end
        end
        pocd_pkg::FMT_INIT: begin
          if (!busy_q) begin
            init_go_d = 1'b1;
            cmd_d = w;
            busy_d = 1'b1;
            block_mode_d = HAS_BLOCK && w[pocd_pkg::B_MODE];
            dir_in_d = w[pocd_pkg::B_DIR];
            data_conn_d = w[pocd_pkg::B_DATA];
            svc_conn_d = w[pocd_pkg::B_SVC];
            if (!w[pocd_pkg::B_DATA]) begin
              data_pend_d = 1'b0;
            end
            if (!w[pocd_pkg::B_SVC]) begin
              svc_pend_d = 1'b0;
            end
          end
        end
      endcase
    end
    // Engine events; data request source depends on last mode
    if (block_mode_q) begin
      data_evt = data_evt || (count_zero && data_conn_q);
    end else begin
      data_evt = data_evt || (word_need && data_conn_q);
    end
    if (checks_done) begin
      busy_d = 1'b0;
      svc_evt = 1'b1;
    end
    // Raising wins over any clear in the same cycle, except a service disconnect, which blocks the raise
    if (data_evt) begin
      data_pend_d = 1'b1;
    end
    if (svc_evt && svc_conn_d) begin
      svc_pend_d = 1'b1;
    end
    // Data-ready tracking for polled transfers
    if (word_taken || stop_d) begin
      rdy_d = 1'b0;
    end
    if (word_need && !block_mode_q) begin
      rdy_d = 1'b1;
    end
    if (xfer_err) begin
      xerr_d = 1'b1;
    end
    if (dev_perr) begin
      perr_d = 1'b1;
    end
  end

  // Status word answered in the cycle after the read strobe
  always_comb begin
    stat_d = pocd_pkg::WORD_RST;
    if (bus.stat_rd) begin
      stat_d[pocd_pkg::S_NOERR] = !(xerr_q || perr_q || inoperable || mpe_q);
      stat_d[pocd_pkg::S_XERR] = xerr_q;
      stat_d[pocd_pkg::S_PERR] = perr_q;
      stat_d[pocd_pkg::S_INOP] = inoperable;
      stat_d[pocd_pkg::S_MPE] = mpe_q;
      stat_d[pocd_pkg::S_BUSY] = busy_q;
      stat_d[pocd_pkg::S_NRDY] = !rdy_q;
    end
  end

  // Registering of all state, applied one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_q <= pocd_pkg::WORD_RST;
      select_go_q <= 1'b0;
      init_go_q <= 1'b0;
      ctl_go_q <= 1'b0;
      stop_q <= 1'b0;
      abort_q <= 1'b0;
      busy_q <= 1'b0;
      block_mode_q <= 1'b0;
      dir_in_q <= 1'b0;
      data_conn_q <= 1'b0;
      svc_conn_q <= 1'b0;
      data_pend_q <= 1'b0;
      svc_pend_q <= 1'b0;
      rdy_q <= 1'b0;
      xerr_q <= 1'b0;
      perr_q <= 1'b0;
      mpe_q <= 1'b0;
      stat_q <= pocd_pkg::WORD_RST;
    end else begin
      cmd_q <= cmd_d;
      select_go_q <= select_go_d;
      init_go_q <= init_go_d;
      ctl_go_q <= ctl_go_d;
      stop_q <= stop_d;
      abort_q <= abort_d;
      busy_q <= busy_d;
      block_mode_q <= block_mode_d;
      dir_in_q <= dir_in_d;
      data_conn_q <= data_conn_d;
      svc_conn_q <= svc_conn_d;
      data_pend_q <= data_pend_d;
      svc_pend_q <= svc_pend_d;
      rdy_q <= rdy_d;
      xerr_q <= xerr_d;
      perr_q <= perr_d;
      mpe_q <= mpe_d;
      stat_q <= stat_d;
    end
  end

  // Bus outputs come straight from flip-flops
  assign bus.data_irq = data_pend_q;
  assign bus.svc_irq = svc_pend_q;
  assign bus.stat_word = stat_q;
endmodule
`default_nettype wire

// ==== rtl/pocd_host.sv ====
// Purpose: Host I/O subsystem end: issues commands, reads status, acks
// Assumes: Software drives a plain register port, read data one cycle later
// Notes: Refused initiates set a sticky flag instead of reaching the bus
`timescale 1ns/1ps
`default_nettype none
module pocd_host (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Software register port
  input  wire logic [3:0]              addr,
  input  wire logic [pocd_pkg::CW-1:0] wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic [pocd_pkg::CW-1:0]      rdata_q,
  // Block engine parity event
  input  wire logic                    mpe_evt,
  // I/O bus
  pocd_bus_if.host                     bus
);
  logic                    cv_q, cv_d, srd_q, srd_d, swait_q, swait_d;
  logic                    dack_q, dack_d, sack_q, sack_d;
  logic [pocd_pkg::CW-1:0] cw_q, cw_d, stat_q, stat_d, rdata_d;
  logic [pocd_pkg::CW-1:0] adr_q, adr_d, wcnt_q, wcnt_d;
  logic                    ok_q, ok_d, ref_q, ref_d, adr_set_q, adr_set_d;
  logic                    wcnt_set_q, wcnt_set_d;
  logic                    is_init, is_blk;

  // Command issue, status read and acknowledge
  always_comb begin
    cv_d = 1'b0;
    cw_d = cw_q;
    srd_d = 1'b0;
    swait_d = srd_q;
    dack_d = 1'b0;
    sack_d = 1'b0;
    stat_d = stat_q;
    ok_d = ok_q;
    ref_d = ref_q;
    adr_d = adr_q;
    wcnt_d = wcnt_q;
    adr_set_d = adr_set_q;
    wcnt_set_d = wcnt_set_q;
    is_init = wdata[pocd_pkg::B_F0];
    is_blk = is_init && wdata[pocd_pkg::B_MODE];
    if (swait_q) begin
      stat_d = bus.stat_word;
      ok_d = (bus.stat_word != pocd_pkg::WORD_RST) && !bus.stat_word[pocd_pkg::S_INOP];
    end
    if (mpe_evt) begin
      cv_d = 1'b1;
      cw_d = pocd_pkg::CW'((1 << pocd_pkg::B_F1) | (1 << pocd_pkg::B_TERM) | (1 << pocd_pkg::B_MPE));
      ref_d = ref_q || (wr && addr == pocd_pkg::R_CMD);
    end else if (wr && addr == pocd_pkg::R_CMD) begin
      if (is_init && (!ok_q || (is_blk && !(adr_set_q && wcnt_set_q)))) begin
        ref_d = 1'b1;
      end else begin
        cv_d = 1'b1;
        cw_d = wdata;
        if (is_init) begin
          ok_d = 1'b0;
          adr_set_d = 1'b0;
          wcnt_set_d = 1'b0;
        end
      end
    end
    if (wr) begin
      unique case (addr)
        pocd_pkg::R_STAT: srd_d = 1'b1;
        pocd_pkg::R_IRQ: begin
          dack_d = wdata[0];
          sack_d = wdata[1];
        end
        pocd_pkg::R_ADR: begin
          adr_d = wdata;
          adr_set_d = 1'b1;
        end
        pocd_pkg::R_WCNT: begin
          wcnt_d = wdata;
          wcnt_set_d = 1'b1;
        end
        pocd_pkg::R_FLAG: ref_d = ref_d && !wdata[1];
        default: ;
      endcase
    end
  end

  // Read mux, data in the cycle after the strobe
  always_comb begin
    rdata_d = pocd_pkg::WORD_RST;
    if (rd) begin
      unique case (addr)
        pocd_pkg::R_CMD: rdata_d = cw_q;
        pocd_pkg::R_STAT: rdata_d = stat_q;
        pocd_pkg::R_IRQ: rdata_d = {14'h0000, bus.svc_irq, bus.data_irq};
        pocd_pkg::R_ADR: rdata_d = adr_q;
        pocd_pkg::R_WCNT: rdata_d = wcnt_q;
        pocd_pkg::R_FLAG: rdata_d = {12'h000, wcnt_set_q, adr_set_q, ref_q, ok_q};
        default: rdata_d = pocd_pkg::WORD_RST;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cv_q <= 1'b0;
      cw_q <= pocd_pkg::WORD_RST;
      srd_q <= 1'b0;
      swait_q <= 1'b0;
      dack_q <= 1'b0;
      sack_q <= 1'b0;
      stat_q <= pocd_pkg::WORD_RST;
      ok_q <= 1'b0;
      ref_q <= 1'b0;
      adr_q <= pocd_pkg::WORD_RST;
      wcnt_q <= pocd_pkg::WORD_RST;
      adr_set_q <= 1'b0;
      wcnt_set_q <= 1'b0;
      rdata_q <= pocd_pkg::WORD_RST;
    end else begin
      cv_q <= cv_d;
      cw_q <= cw_d;
      srd_q <= srd_d;
      swait_q <= swait_d;
      dack_q <= dack_d;
      sack_q <= sack_d;
      stat_q <= stat_d;
      ok_q <= ok_d;
      ref_q <= ref_d;
      adr_q <= adr_d;
      wcnt_q <= wcnt_d;
      adr_set_q <= adr_set_d;
      wcnt_set_q <= wcnt_set_d;
      rdata_q <= rdata_d;
    end
  end

  // Bus drive from flip-flops
  assign bus.cmd_valid = cv_q;
  assign bus.cmd_word = cw_q;
  assign bus.stat_rd = srd_q;
  assign bus.data_ack = dack_q;
  assign bus.svc_ack = sack_q;
endmodule
`default_nettype wire

// ==== tb/pocd_bus_asserts.sv ====
// Purpose: Concurrent checks on the link between host and controller
// Assumes: One clock, synchronous active-high reset
// Notes: Sees only interface signals; bench keeps engine events away from commands
`timescale 1ns/1ps
`default_nettype none
module pocd_bus_asserts (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    sys_rst,
  // Host to controller
  input wire logic                    cmd_valid,
  input wire logic [pocd_pkg::CW-1:0] cmd_word,
  input wire logic                    stat_rd,
  input wire logic                    data_ack,
  input wire logic                    svc_ack,
  // Controller to host
  input wire logic [pocd_pkg::CW-1:0] stat_word,
  input wire logic                    data_irq,
  input wire logic                    svc_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Command shapes on the bus
  sequence s_dconn;
    cmd_valid && cmd_word[1:0] == 2'h2 && cmd_word[2] && cmd_word[6:4] == 3'h0;
  endsequence
  sequence s_ddis;
    cmd_valid && cmd_word[1:0] == 2'h2 && !cmd_word[2] && cmd_word[6:4] == 3'h0;
  endsequence
  sequence s_eob;
    cmd_valid && cmd_word[1:0] == 2'h2 && cmd_word[4] && !cmd_word[5] && cmd_word[3:2] == 2'h0;
  endsequence

  // Status word only answers a read
  stat_idle_a: assert property (!stat_rd |=> stat_word == 16'h0000)
    else $error("status word driven without a read");
  stat_resv_a: assert property (stat_word[15:10] == 6'h00 && stat_word[7:5] == 3'h0)
    else $error("reserved status bits set");
  stat_valid_a: assert property (stat_rd |=> stat_word != 16'h0000)
    else $error("all-zero status answered");
  noerr_bit_a: assert property (stat_rd |=> stat_word[0] == !(|stat_word[4:1]))
    else $error("no-error bit disagrees with error bits");
  // Disconnect and terminate drop a data request; disconnect drops a service request
  data_clr_a: assert property (cmd_valid && cmd_word[1:0] == 2'h2
      && (cmd_word[5] || (!cmd_word[4] && !cmd_word[2])) |=> !data_irq)
    else $error("data request survived disconnect or terminate");
  svc_clr_a: assert property (cmd_valid && cmd_word[1:0] == 2'h2 && cmd_word[5:3] == 3'h0 |=> !svc_irq)
    else $error("service request survived disconnect");
  // End-of-block follows the data connection
  eob_raise_a: assert property (s_dconn ##2 s_eob |=> data_irq)
    else $error("end-of-block did not raise data request");
  eob_quiet_a: assert property (s_ddis ##2 s_eob |=> !data_irq)
    else $error("end-of-block raised while disconnected");
  // Acknowledge drops the request when no command competes
  dack_clr_a: assert property (data_ack && !cmd_valid |=> !data_irq)
    else $error("data request survived its acknowledge");
  sack_clr_a: assert property (svc_ack && !cmd_valid |=> !svc_irq)
    else $error("service request survived its acknowledge");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the host and controller pair
// Assumes: 10 MHz clock, reset held four cycles
// Notes: Status bit 9 is masked where the data-ready state is not set up
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk;
  logic        sys_rst;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [6:0]  ev;
  logic        inoperable;
  logic [15:0] rdata_q;
  logic [15:0] cmd_q;
  logic [15:0] s;
  logic [15:0] w;
  logic        select_go_q;
  logic        init_go_q;
  logic        ctl_go_q;
  logic        stop_q;
  logic        abort_q;
  logic        busy_q;
  logic        block_mode_q;
  logic        dir_in_q;
  int          error_cnt;
  int          cmp_count;
  int unsigned seed_v;

  pocd_bus_if bus ();
  // Both ends face each other; ev bits feed the engine events and parity event
  pocd_dev i_pocd_dev (.clk(clk), .sys_rst(sys_rst), .bus(bus.dev), .word_need(ev[0]), .word_taken(ev[1]),
    .count_zero(ev[2]), .checks_done(ev[3]), .xfer_err(ev[4]), .dev_perr(ev[5]), .inoperable(inoperable),
    .select_go_q(select_go_q), .init_go_q(init_go_q), .ctl_go_q(ctl_go_q), .stop_q(stop_q), .abort_q(abort_q),
    .cmd_q(cmd_q), .busy_q(busy_q), .block_mode_q(block_mode_q), .dir_in_q(dir_in_q));
  pocd_host i_pocd_host (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .mpe_evt(ev[6]), .bus(bus.host));
  pocd_bus_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .cmd_valid(bus.cmd_valid), .cmd_word(bus.cmd_word),
    .stat_rd(bus.stat_rd), .data_ack(bus.data_ack), .svc_ack(bus.svc_ack), .stat_word(bus.stat_word),
    .data_irq(bus.data_irq), .svc_irq(bus.svc_irq));

  // Clock
  always #50 clk = ~clk;

  // Expected status word from the stored conditions
  function automatic logic [15:0] exp_stat(input logic xe, input logic pe, input logic inop, input logic mpe);
    exp_stat = 16'h0000;
    exp_stat[pocd_pkg::S_XERR] = xe;
    exp_stat[pocd_pkg::S_PERR] = pe;
    exp_stat[pocd_pkg::S_INOP] = inop;
    exp_stat[pocd_pkg::S_MPE] = mpe;
    exp_stat[pocd_pkg::S_NOERR] = !(xe || pe || inop || mpe);
  endfunction

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register port cycles
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk) begin
      addr <= a;
      rd <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata_q;
  endtask
  task automatic settle;
    @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [15:0] c);
    wr_reg(pocd_pkg::R_CMD, c);
  endtask
  task automatic get_stat;
    wr_reg(pocd_pkg::R_STAT, 16'h0000);
    @(posedge clk);
    rd_reg(pocd_pkg::R_STAT, s);
  endtask
  task automatic ev_pulse(input int b);
    @(posedge clk) ev <= 7'h01 << b;
    @(posedge clk) ev <= 7'h00;
    #1;
  endtask
  task automatic ack(input logic [15:0] m);
    wr_reg(pocd_pkg::R_IRQ, m);
    settle;
  endtask

  task automatic give_verdict;
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict;
  end

  // Main sequence
  initial begin
    clk = 1'b0; sys_rst = 1'b1; addr = 4'h0; wdata = 16'h0000;
    wr = 1'b0; rd = 1'b0; ev = 7'h00; inoperable = 1'b0;
    error_cnt = 0; cmp_count = 0;
    seed_v = $urandom(88731);
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk(16'({bus.data_irq, bus.svc_irq, busy_q, block_mode_q}), 16'h0000);
    // Clean status, then data-ready bit after a word is taken
    get_stat; chk(s & 16'hfdff, exp_stat(0, 0, 0, 0));
    ev_pulse(1); get_stat; chk(16'(s[pocd_pkg::S_NRDY]), 16'h0001);
    // Stored errors and inoperable; host refuses the initiate
    ev_pulse(4); ev_pulse(5); @(posedge clk) inoperable <= 1'b1;
    get_stat; chk(s & 16'hfdff, exp_stat(1, 1, 1, 0));
    cmd(16'h000d); settle; chk(16'(busy_q), 16'h0000);
    rd_reg(pocd_pkg::R_FLAG, s); chk(s & 16'h0003, 16'h0002);
    wr_reg(pocd_pkg::R_FLAG, 16'h0002); inoperable <= 1'b0;
    // End-of-block keeps status, no-op clears it
    cmd(16'h0012); get_stat; chk(s & 16'hfdff, exp_stat(1, 1, 0, 0));
    cmd(16'h0002); cmd(16'h0012); get_stat; chk(s & 16'hfdff, exp_stat(0, 0, 0, 0));
    // Random select and control function words
    for (int i = 0; i < 6; i++) begin
      w = 16'($urandom);
      if (i % 2 == 0) w[1:0] = 2'h0;
      else w[6:0] = {1'b1, w[5:4] & 2'h0, 4'h2};
      cmd(w); settle;
      chk(16'({select_go_q, ctl_go_q}), (i % 2 == 0) ? 16'h0002 : 16'h0001);
      chk(cmd_q, w);
    end
    // Register mode transfer
    get_stat; cmd(16'h001d); settle;
    chk(16'({init_go_q, busy_q, block_mode_q, dir_in_q}), 16'h000d);
    ev_pulse(0); chk(16'(bus.data_irq), 16'h0001);
    ack(16'h0001); chk(16'(bus.data_irq), 16'h0000);
    get_stat; chk(16'({s[pocd_pkg::S_BUSY], s[pocd_pkg::S_NRDY]}), 16'h0002);
    ev_pulse(1); get_stat; chk(16'(s[pocd_pkg::S_NRDY]), 16'h0001);
    cmd(16'h000d); settle; chk(16'(init_go_q), 16'h0000);
    cmd(16'h0012); settle; chk(16'(bus.data_irq), 16'h0001);
    ack(16'h0001); ev_pulse(3); chk(16'({busy_q, bus.svc_irq}), 16'h0001);
    ack(16'h0002);
    // Block mode refused without address and count
    get_stat; cmd(16'h000f); settle; chk(16'(busy_q), 16'h0000);
    rd_reg(pocd_pkg::R_FLAG, s); chk(s & 16'h0002, 16'h0002);
    wr_reg(pocd_pkg::R_FLAG, 16'h0002);
    wr_reg(pocd_pkg::R_ADR, 16'($urandom)); wr_reg(pocd_pkg::R_WCNT, 16'($urandom));
    get_stat; cmd(16'h000f); settle;
    chk(16'({init_go_q, busy_q, block_mode_q}), 16'h0007);
    ev_pulse(0); chk(16'(bus.data_irq), 16'h0000);
    ev_pulse(2); chk(16'(bus.data_irq), 16'h0001);
    ack(16'h0001); cmd(16'h0004); settle; chk(16'(select_go_q), 16'h0000);
    // Parity terminate from the host while busy
    ev_pulse(6); chk(bus.cmd_word, 16'h00a2);
    settle; chk(16'({stop_q, bus.svc_irq, abort_q}), 16'h0004);
    ev_pulse(3); chk(16'(bus.svc_irq), 16'h0001);
    ack(16'h0002); get_stat; chk(s & 16'hfdff, exp_stat(0, 0, 0, 1));
    // Idle terminate raises service at once; its bit 2 is ignored
    cmd(16'h000a); cmd(16'h0026); settle; chk(16'({stop_q, bus.svc_irq}), 16'h0003);
    cmd(16'h0012); settle; chk(16'(bus.data_irq), 16'h0000);
    cmd(16'h0006); cmd(16'h0012); settle; chk(16'({bus.data_irq, bus.svc_irq}), 16'h0002);
    give_verdict;
  end
endmodule
`default_nettype wire
